// File: chgsup_consts.svh
// constants for the charge supervisor control block
`ifndef CHGSUP_CONSTS_SVH
`define CHGSUP_CONSTS_SVH
`define CHGSUP_CLK_MHZ 250
// control word bit positions
`define CHGSUP_W3_AUTO_EN_BIT 7
`define CHGSUP_W3_EOC_DEB_BIT 13
`define CHGSUP_W3_WDOG_LO_BIT 11
`define CHGSUP_W3_WDOG_HI_BIT 12
`define CHGSUP_W1_WDOG_OFF_BIT 7
`define CHGSUP_W1X_LEARN_EXIT_BIT 12
`define CHGSUP_W1X_LEARN_VMIN_BIT 13
`define CHGSUP_W7_EOC_LO_BIT 8
`define CHGSUP_W7_EOC_HI_BIT 9
`define CHGSUP_W2_PROF_HI_BIT 5
`define CHGSUP_W4_PROF_LO_BIT 14
`define CHGSUP_CHARGE_AMP_ADDR 8'h14
// times in their own units
`define CHGSUP_ENTRY_DEB_US 1000
`define CHGSUP_EOC_SHORT_MS 20
`define CHGSUP_EOC_LONG_MS 200
`define CHGSUP_AUTO_LIMIT_H 12
`define CHGSUP_WDOG_DEFAULT_S 175
`define CHGSUP_ENTRY_DEB_CYC (`CHGSUP_ENTRY_DEB_US * `CHGSUP_CLK_MHZ)
`define CHGSUP_EOC_SHORT_CYC (`CHGSUP_EOC_SHORT_MS * 1000 * `CHGSUP_CLK_MHZ)
`define CHGSUP_EOC_LONG_CYC (`CHGSUP_EOC_LONG_MS * 1000 * `CHGSUP_CLK_MHZ)
`define CHGSUP_AUTO_LIMIT_CYC (64'd`CHGSUP_AUTO_LIMIT_H * 64'd3600 * 64'd1000000 * 64'd`CHGSUP_CLK_MHZ)
`define CHGSUP_WDOG_DEFAULT_CYC (64'd`CHGSUP_WDOG_DEFAULT_S * 64'd1000000 * 64'd`CHGSUP_CLK_MHZ)
`endif

// File: chgsup_pkg.sv
// types for the charge supervisor control block
package chgsup_pkg;
  // autonomous charge sequence, gray along idle-debounce-charge-fault
  typedef enum logic [1:0] {
    CHGSUP_IDLE = 2'b00,
    CHGSUP_DEBOUNCE = 2'b01,
    CHGSUP_AUTO = 2'b11,
    CHGSUP_FAULT = 2'b10
  } chgsup_state_type;
  typedef enum logic [1:0] {
    CHGSUP_PROF_OFF = 2'b00,
    CHGSUP_PROF_CELLS = 2'b01,
    CHGSUP_PROF_ONE = 2'b10,
    CHGSUP_PROF_TWO = 2'b11
  } chgsup_prof_type;
endpackage

// File: chgsup_timer.sv
// hold timer: counts while a condition stands, flags when the limit is met
`timescale 1ns/1ns
`default_nettype none
module chgsup_timer (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // control
  input wire logic run,
  input wire logic [63:0] limit,
  // status
  output logic done
);
  logic [63:0] count;

  // =========================================
  // counter, restarts whenever run drops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= 64'h0000_0000_0000_0000;
    end else if (clkEn) begin
      if (!run) begin
        count <= 64'h0000_0000_0000_0000;
      end else if (count < limit) begin
        count <= count + 64'h0000_0000_0000_0001;
      end
    end
  end

  // limit reached; a zero limit never fires
  assign done = run && (limit != 64'h0000_0000_0000_0000) && (count >= limit);
endmodule // chgsup_timer
`default_nettype wire

// File: chgsup_ctrl.sv
// charge supervisor: autonomous charge, watchdog, learn mode, battery-absent, profile
`timescale 1ns/1ns
`default_nettype none
`include "chgsup_consts.svh"
module chgsup_ctrl import chgsup_pkg::*; #(
  parameter logic [63:0] ENTRY_DEB_CYC = 64'(`CHGSUP_ENTRY_DEB_CYC),
  parameter logic [63:0] EOC_SHORT_CYC = 64'(`CHGSUP_EOC_SHORT_CYC),
  parameter logic [63:0] EOC_LONG_CYC = 64'(`CHGSUP_EOC_LONG_CYC),
  parameter logic [63:0] AUTO_LIMIT_CYC = `CHGSUP_AUTO_LIMIT_CYC,
  parameter logic [63:0] WDOG_CYC0 = `CHGSUP_WDOG_DEFAULT_CYC,
  parameter logic [63:0] WDOG_CYC1 = `CHGSUP_WDOG_DEFAULT_CYC * 64'd2,
  parameter logic [63:0] WDOG_CYC2 = `CHGSUP_WDOG_DEFAULT_CYC * 64'd4,
  parameter logic [63:0] WDOG_CYC3 = 64'h0000_0000_0000_0000
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // control words
  input wire logic [15:0] cfgWordFirst,
  input wire logic [15:0] cfgWordFirstExt,
  input wire logic [15:0] cfgWordSecond,
  input wire logic [15:0] cfgWordFourth,
  input wire logic [15:0] cfgWordSeventh,
  input wire logic [15:0] cfgWordThirdIn,
  input wire logic cfgWordThirdWr,
  // host register writes
  input wire logic [15:0] chargeAmpSetting,
  input wire logic chargeAmpWr,
  input wire logic upperVoltageWr,
  // analog comparator results
  input wire logic batteryLowVsUpper,
  input wire logic currentBelowEoc,
  input wire logic cvLoopActive,
  input wire logic batteryBelowFloor,
  input wire logic faultEvent,
  input wire logic thermistorSampling,
  input wire logic batteryAbsentPin,
  // mode requests
  input wire logic narrowDirectCharge,
  input wire logic learnEnterCmd,
  input wire logic reverseRequest,
  input wire logic hotThrottleNormal,
  // outputs
  output logic [15:0] cfgWordThird,
  output logic [15:0] chargeTarget,
  output logic [1:0] eocThreshold,
  output logic chargingActive,
  output logic batteryFetGate,
  output logic switcherOn,
  output logic vsysRegulation,
  output logic learnMode,
  output logic reverseEnable,
  output logic hotThrottlePinOe,
  output logic absentPullupOn,
  output logic thermistorSourceOn,
  output chgsup_prof_type thermalChargeProfile,
  output chgsup_state_type autoState,
  output logic watchdogExpired
);
  chgsup_state_type next_autoState;
  logic autoEnable;
  logic entryDone, eocDone, limitDone, wdogDone;
  logic absentSeen, learnExit, wdogRun, limitStopped;
  logic [63:0] eocLimit, wdogLimit;

  // =========================================
  // shared helpers
  function automatic logic [63:0] wdog_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: wdog_limit = WDOG_CYC0;
      2'b01: wdog_limit = WDOG_CYC1;
      2'b10: wdog_limit = WDOG_CYC2;
      2'b11: wdog_limit = WDOG_CYC3;
    endcase
  endfunction

  assign autoEnable = cfgWordThird[`CHGSUP_W3_AUTO_EN_BIT];

  // =========================================
  // third control word, hardware clears the enable bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgWordThird <= 16'h0000;
    end else if (clkEn) begin
      if (cfgWordThirdWr) begin
        cfgWordThird <= cfgWordThirdIn;
      end
      // fault clears enable
      // clear applied last so a hardware event beats a host write
      if ((autoState == CHGSUP_AUTO && limitDone) || faultEvent) begin
        cfgWordThird[`CHGSUP_W3_AUTO_EN_BIT] <= 1'b0;
      end
    end
  end

  // =========================================
  // hold timers: entry debounce, end of charge, duration, watchdog
  // entry debounce 1ms
  chgsup_timer entryTimer (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .run(autoState == CHGSUP_DEBOUNCE && batteryLowVsUpper && batteryFetGate),
    .limit(ENTRY_DEB_CYC), .done(entryDone));
  assign eocLimit = cfgWordThird[`CHGSUP_W3_EOC_DEB_BIT] ? EOC_LONG_CYC : EOC_SHORT_CYC;
  chgsup_timer eocTimer (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .run(autoState == CHGSUP_AUTO && currentBelowEoc && cvLoopActive),
    .limit(eocLimit), .done(eocDone));
  chgsup_timer limitTimer (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .run(autoState == CHGSUP_AUTO), .limit(AUTO_LIMIT_CYC), .done(limitDone));
  assign wdogLimit = wdog_limit(cfgWordThird[`CHGSUP_W3_WDOG_HI_BIT:`CHGSUP_W3_WDOG_LO_BIT]);
  assign wdogRun = !autoEnable && !cfgWordFirst[`CHGSUP_W1_WDOG_OFF_BIT]
    && !chargeAmpWr && !upperVoltageWr && !watchdogExpired;
  chgsup_timer wdogTimer (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .run(wdogRun), .limit(wdogLimit), .done(wdogDone));

  // =========================================
  // watchdog expiry latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdogExpired <= 1'b0;
    end else if (clkEn) begin
      if (chargeAmpWr || upperVoltageWr) begin
        watchdogExpired <= 1'b0;
      end else if (wdogDone) begin
        watchdogExpired <= 1'b1;
      end
    end
  end

  // limit stop holds until a host write; set wins over a same-cycle write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      limitStopped <= 1'b0;
    end else if (clkEn) begin
      if (autoState == CHGSUP_AUTO && limitDone) begin
        limitStopped <= 1'b1;
      end else if (chargeAmpWr || upperVoltageWr) begin
        limitStopped <= 1'b0;
      end
    end
  end

  // =========================================
  // autonomous sequence
  always_comb begin
    next_autoState = autoState;
    unique case (autoState)
      CHGSUP_IDLE: begin
        if (autoEnable) begin
          next_autoState = CHGSUP_DEBOUNCE;
        end
      end
      CHGSUP_DEBOUNCE: begin
        if (!autoEnable) begin
          next_autoState = CHGSUP_IDLE;
        end else if (entryDone) begin
          next_autoState = CHGSUP_AUTO;
        end
      end
      CHGSUP_AUTO: begin
        if (limitDone || !autoEnable) begin
          next_autoState = CHGSUP_IDLE;
        end else if (eocDone) begin
          next_autoState = CHGSUP_DEBOUNCE;
        end
      end
      CHGSUP_FAULT: begin
        if (!cfgWordFirst[`CHGSUP_W1_WDOG_OFF_BIT]) begin
          next_autoState = CHGSUP_IDLE;
        end
      end
    endcase
    if (faultEvent) begin
      next_autoState = cfgWordFirst[`CHGSUP_W1_WDOG_OFF_BIT] ? CHGSUP_FAULT : CHGSUP_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      autoState <= CHGSUP_IDLE;
    end else if (clkEn) begin
      autoState <= next_autoState;
    end
  end

  // =========================================
  // learn mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      absentSeen <= 1'b0;
    end else if (clkEn) begin
      absentSeen <= batteryAbsentPin;
    end
  end

  assign learnExit = cfgWordFirstExt[`CHGSUP_W1X_LEARN_EXIT_BIT]
    || (cfgWordFirstExt[`CHGSUP_W1X_LEARN_VMIN_BIT] && batteryBelowFloor)
    || (batteryAbsentPin && !absentSeen) || batteryAbsentPin;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      learnMode <= 1'b0;
    end else if (clkEn) begin
      if (learnExit) begin
        learnMode <= 1'b0;
      end else if (learnEnterCmd && narrowDirectCharge) begin
        learnMode <= 1'b1;
      end
    end
  end

  // =========================================
  // power path outputs, registered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      batteryFetGate <= 1'b1;
      switcherOn <= 1'b1;
      chargingActive <= 1'b0;
      vsysRegulation <= 1'b1;
      chargeTarget <= 16'h0000;
      reverseEnable <= 1'b0;
      eocThreshold <= 2'b00;
    end else if (clkEn) begin
      switcherOn <= !(learnMode && !learnExit);
      batteryFetGate <= learnMode || !(watchdogExpired || wdogDone);
      chargingActive <= !watchdogExpired && !wdogDone && !learnMode && !limitStopped
        && autoState != CHGSUP_FAULT && chargeAmpSetting != 16'h0000;
      vsysRegulation <= watchdogExpired || wdogDone || limitStopped || chargeAmpSetting == 16'h0000;
      eocThreshold <= cfgWordSeventh[`CHGSUP_W7_EOC_HI_BIT:`CHGSUP_W7_EOC_LO_BIT];
      chargeTarget <= chargeAmpSetting;
      reverseEnable <= reverseRequest && !batteryAbsentPin && !autoEnable;
    end
  end

  // =========================================
  // pins and profile select
  // indicator in autonomous mode
  assign hotThrottlePinOe = (autoState == CHGSUP_AUTO) || (autoEnable ? 1'b0 : hotThrottleNormal);
  assign absentPullupOn = !thermistorSampling;
  assign thermalChargeProfile = chgsup_prof_type'({cfgWordSecond[`CHGSUP_W2_PROF_HI_BIT],
    cfgWordFourth[`CHGSUP_W4_PROF_LO_BIT]});
  assign thermistorSourceOn = thermalChargeProfile != CHGSUP_PROF_OFF;

  // =========================================
  // checks
  auto_limit_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && autoState == CHGSUP_AUTO && limitDone) |=> !autoEnable && autoState == CHGSUP_IDLE)
    else $error("duration limit did not end autonomous charging");
  fault_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && faultEvent) |=> !autoEnable)
    else $error("fault left autonomous enable set");
  throttle_ind_a: assert property (@(posedge clk) disable iff (sys_rst)
    (autoState == CHGSUP_AUTO) |-> hotThrottlePinOe)
    else $error("indicator not driven in autonomous mode");
  learn_path_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && learnMode && !learnExit) |=> !switcherOn && batteryFetGate)
    else $error("learn mode power path wrong");
  learn_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !learnMode && !narrowDirectCharge) |=> !learnMode)
    else $error("learn entered outside narrow direct charge");
  absent_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && batteryAbsentPin) |=> !learnMode && !reverseEnable)
    else $error("absent battery did not block modes");
  wdog_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && wdogDone && !learnMode) |=> !batteryFetGate && !chargingActive)
    else $error("watchdog expiry left charging on");
  wdog_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && (cfgWordFirst[`CHGSUP_W1_WDOG_OFF_BIT] || autoEnable) && !watchdogExpired) |=> !watchdogExpired)
    else $error("watchdog runs while suppressed");
endmodule // chgsup_ctrl
`default_nettype wire

// File: chgsup_host_model.sv
// host model that keeps the charger watchdog fed with register writes
`timescale 1ns/1ns
`default_nettype none
module chgsup_host_model #(
  parameter int KICK_GAP = 16
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic keepAlive,
  input wire logic kickNow,
  // register write strobes
  output logic chargeAmpWr,
  output logic upperVoltageWr
);
  int gap;
  logic pick;
  always @(posedge clk) begin
    chargeAmpWr <= 1'b0;
    upperVoltageWr <= 1'b0;
    gap <= gap + 1;
    // no writes during reset; alternate registers so both feed the timer
    if (sys_rst) begin
      gap <= 0;
      pick <= 1'b0;
    end else if (kickNow || (keepAlive && gap >= KICK_GAP)) begin
      gap <= 0;
      pick <= !pick;
      chargeAmpWr <= !pick;
      upperVoltageWr <= pick;
    end
  end
endmodule // chgsup_host_model
`default_nettype wire

// File: chgsup_ctrl_bench.sv
// self-checking bench for the charge supervisor control block
`timescale 1ns/1ns
`default_nettype none
module chgsup_ctrl_bench import chgsup_pkg::*;;
  typedef struct {int s; logic [15:0] e;} chgsup_note_type;
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, w3Wr = 1'b0, ampWr, upWr, keep = 1'b1, kick = 1'b0;
  logic batLow = 1'b0, curLow = 1'b0, cv = 1'b0, belowFloor = 1'b0, fault = 1'b0, sampling = 1'b0;
  logic absent = 1'b0, ndc = 1'b0, learnCmd = 1'b0, revReq = 1'b0, hotNorm = 1'b0;
  logic [15:0] w1 = 16'h0, w1x = 16'h0, w2 = 16'h0, w4 = 16'h0, w7 = 16'h0, w3In = 16'h0, amp = 16'h0;
  logic [15:0] w3, tgt, rnd = 16'h35;
  logic chg, gate, sw, vsys, learn, rev, hotOe, pull, thSrc, wdExp;
  logic [1:0] eoc;
  chgsup_prof_type prof;
  chgsup_state_type st;
  chgsup_note_type notes[$];
  int nMismatch = 0, samplesChecked = 0;
  string nm[15] = '{"state", "autoEn", "hot", "gate", "sw", "learn", "tgt", "prof", "thSrc", "pull",
    "rev", "wdExp", "chg", "vsys", "eoc"};
  // ==========================================
  // clock, design and host
  always #2 clk = ~clk;
  // short timers keep the run brief
  chgsup_ctrl #(.ENTRY_DEB_CYC(64'h4), .EOC_SHORT_CYC(64'h8), .EOC_LONG_CYC(64'h10), .AUTO_LIMIT_CYC(64'h40),
    .WDOG_CYC0(64'h20)) DUT (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .cfgWordFirst(w1), .cfgWordFirstExt(w1x),
    .cfgWordSecond(w2), .cfgWordFourth(w4), .cfgWordSeventh(w7), .cfgWordThirdIn(w3In), .cfgWordThirdWr(w3Wr),
    .chargeAmpSetting(amp), .chargeAmpWr(ampWr), .upperVoltageWr(upWr), .batteryLowVsUpper(batLow),
    .currentBelowEoc(curLow), .cvLoopActive(cv), .batteryBelowFloor(belowFloor), .faultEvent(fault),
    .thermistorSampling(sampling), .batteryAbsentPin(absent), .narrowDirectCharge(ndc),
    .learnEnterCmd(learnCmd), .reverseRequest(revReq), .hotThrottleNormal(hotNorm), .cfgWordThird(w3),
    .chargeTarget(tgt), .chargingActive(chg), .batteryFetGate(gate), .switcherOn(sw), .vsysRegulation(vsys),
    .learnMode(learn), .reverseEnable(rev), .hotThrottlePinOe(hotOe), .absentPullupOn(pull),
    .thermistorSourceOn(thSrc), .thermalChargeProfile(prof), .autoState(st), .watchdogExpired(wdExp),
    .eocThreshold(eoc));
  chgsup_host_model host (.clk(clk), .sys_rst(sys_rst), .keepAlive(keep), .kickNow(kick),
    .chargeAmpWr(ampWr), .upperVoltageWr(upWr));
  // ==========================================
  // helpers
  function automatic logic [15:0] obs(int s);
    case (s)
      0: obs = {14'h0, st};
      1: obs = {15'h0, w3[7]};
      2: obs = {15'h0, hotOe};
      3: obs = {15'h0, gate};
      4: obs = {15'h0, sw};
      5: obs = {15'h0, learn};
      6: obs = tgt;
      7: obs = {14'h0, prof};
      8: obs = {15'h0, thSrc};
      9: obs = {15'h0, pull};
      10: obs = {15'h0, rev};
      11: obs = {15'h0, wdExp};
      12: obs = {15'h0, chg};
      13: obs = {15'h0, vsys};
      default: obs = {14'h0, eoc};
    endcase
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // note at the negedge; the monitor compares at the next posedge, before updates land
  task automatic see(int s, logic [15:0] e);
    @(negedge clk);
    notes.push_back('{s, e});
  endtask
  // bounded wait; a miss shows up as a mismatch of the note
  task automatic waitfor(int s, logic [15:0] e, int m);
    repeat (m) begin
      @(negedge clk);
      if (obs(s) === e) break;
    end
    notes.push_back('{s, e});
  endtask
  task automatic arm(logic [15:0] v);
    @(posedge clk);
    w3In <= v;
    w3Wr <= 1'b1;
    @(posedge clk);
    w3Wr <= 1'b0;
  endtask
  task automatic pulse_learn();
    @(posedge clk);
    learnCmd <= 1'b1;
    @(posedge clk);
    learnCmd <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // monitor: oldest note against the outputs
  always @(posedge clk) begin
    chgsup_note_type n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      samplesChecked++;
      if (obs(n.s) !== n.e) begin
        nMismatch++;
        $display("CHECK FAILED %s expected %h seen %h", nm[n.s], n.e, obs(n.s));
      end
    end
  end
  // watchdog for a hung run
  initial begin
    #40000;
    nMismatch++;
    conclude();
  end
  // ==========================================
  // scenarios
  initial begin
    cyc(16);
    rnd = lfsr(rnd);
    sys_rst <= 1'b0;
    see(0, 16'h0);
    see(3, 16'h1);
    see(4, 16'h1);
    see(13, 16'h1);
    // setting applied only after the reset values are seen
    @(posedge clk);
    amp <= rnd;
    arm(16'h0080);
    batLow <= 1'b1;
    // the write lands at one edge, the state moves at the next
    cyc(1);
    see(0, 16'h1);
    cyc(2);
    see(0, 16'h1);
    waitfor(0, 16'h3, 10);
    see(2, 16'h1);
    see(6, amp);
    @(posedge clk);
    kick <= 1'b1;
    cyc(2);
    kick <= 1'b0;
    cyc(3);
    see(1, 16'h1);
    // termination with both debounce choices
    for (int k = 0; k < 2; k++) begin
      arm(k ? 16'h2080 : 16'h0080);
      curLow <= 1'b1;
      cv <= 1'b1;
      cyc(k ? 12 : 5);
      see(0, 16'h3);
      waitfor(0, 16'h1, 12);
      @(posedge clk);
      curLow <= 1'b0;
      cv <= 1'b0;
      waitfor(0, 16'h3, 10);
    end
    @(posedge clk);
    keep <= 1'b0;
    cyc(40);
    see(0, 16'h3);
    waitfor(1, 16'h0, 40);
    see(12, 16'h0);
    see(2, 16'h0);
    see(11, 16'h0);
    @(posedge clk);
    keep <= 1'b1;
    arm(16'h0080);
    waitfor(0, 16'h3, 12);
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    see(1, 16'h0);
    see(0, 16'h0);
    // fault held while the watchdog is suppressed
    @(posedge clk);
    w1 <= 16'h0080;
    keep <= 1'b0;
    arm(16'h0080);
    waitfor(0, 16'h3, 12);
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    see(0, 16'h2);
    cyc(40);
    see(0, 16'h2);
    see(11, 16'h0);
    @(posedge clk);
    w1 <= 16'h0;
    keep <= 1'b1;
    waitfor(0, 16'h0, 4);
    // host stops writing
    @(posedge clk);
    batLow <= 1'b0;
    keep <= 1'b0;
    cyc(12);
    see(11, 16'h0);
    waitfor(11, 16'h1, 40);
    see(3, 16'h0);
    see(13, 16'h1);
    see(6, amp);
    @(posedge clk);
    keep <= 1'b1;
    waitfor(11, 16'h0, 20);
    see(3, 16'h1);
    // battery absent, pull-up; hardware keeps reverse off while the battery is absent
    @(posedge clk);
    absent <= 1'b1;
    revReq <= 1'b1;
    hotNorm <= 1'b1;
    cyc(3);
    see(10, 16'h0);
    see(9, 16'h1);
    see(2, 16'h1);
    @(posedge clk);
    sampling <= 1'b1;
    absent <= 1'b0;
    see(9, 16'h0);
    cyc(3);
    see(10, 16'h1);
    @(posedge clk);
    revReq <= 1'b0;
    sampling <= 1'b0;
    hotNorm <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      w2 <= {10'h0, p[1], 5'h0};
      w4 <= {1'h0, p[0], 14'h0};
      w7 <= rnd ^ {6'h0, p[1:0], 8'h0};
      see(7, p[15:0]);
      see(8, {15'h0, p != 0});
      see(14, {14'h0, rnd[9:8] ^ p[1:0]});
    end
    // a frozen block ignores a host write
    @(posedge clk);
    clkEn <= 1'b0;
    arm(16'h0080);
    see(1, 16'h0);
    @(posedge clk);
    clkEn <= 1'b1;
    pulse_learn();
    see(5, 16'h0);
    @(posedge clk);
    ndc <= 1'b1;
    // every exit path in turn
    for (int e = 0; e < 3; e++) begin
      pulse_learn();
      see(5, 16'h1);
      see(3, 16'h1);
      see(4, 16'h0);
      @(posedge clk);
      w1x <= (e == 0) ? 16'h1000 : (e == 1) ? 16'h2000 : 16'h0;
      belowFloor <= (e == 1);
      absent <= (e == 2);
      @(posedge clk);
      w1x <= 16'h0;
      belowFloor <= 1'b0;
      absent <= 1'b0;
      see(4, 16'h1);
      see(5, 16'h0);
    end
    cyc(2);
    conclude();
  end
endmodule // chgsup_ctrl_bench
`default_nettype wire
